// [inc/cpu_dec_consts.svh]
`ifndef CPU_DEC_CONSTS_SVH
`define CPU_DEC_CONSTS_SVH

// ****************************************
// opcode bytes
// ****************************************
`define OPC_ROT_LEFT      8'h0c
`define OPC_ROT_RIGHT     8'h2c
`define OPC_SHR_ARITH     8'hac
`define OPC_MOVE_W_RR     8'hf0
`define OPC_MOVE_W_RI     8'he6
`define OPC_MOVE_B_RR     8'hf1
`define OPC_MOVE_B_RI     8'he7
`define OPC_EXT_S_RR      8'hd0
`define OPC_EXT_S_RI      8'hd5
`define OPC_EXT_Z_RR      8'hc0
`define OPC_EXT_Z_RI      8'hc5
`define OPC_JUMP_ABS      8'hea
`define OPC_JUMP_IND      8'h9c
`define OPC_JUMP_REL      8'h0d
`define OPC_JUMP_SEG      8'hfa
`define OPC_JSET          8'h8a
`define OPC_JSET_CLR      8'haa
`define OPC_JCLR          8'h9a
`define OPC_JCLR_SET      8'hba
`define OPC_CALL_ABS      8'hca
`define OPC_CALL_IND      8'hab
`define OPC_CALL_REL      8'hbb
`define OPC_CALL_SEG      8'hda
`define OPC_PUSH_CALL     8'he2
`define OPC_CTX_SWITCH    8'hc6
`define OPC_TRAP          8'h9b
`define OPC_RET_NEAR      8'hcb
`define OPC_RET_NEAR_POP  8'heb
`define OPC_RET_FAR       8'hdb
`define OPC_RET_INT       8'hfb
`define OPC_POWER_DOWN    8'h97
`define OPC_WDT_OFF       8'ha5
`define OPC_WDT_ON        8'h85
`define OPC_XSEG_IMM      8'hd7
`define OPC_XSEG_REG      8'hdc
`define OPC_MAC_LOAD      8'ha3
`define OPC_MAC_STORE     8'hb3

// ****************************************
// condition codes
// ****************************************
`define CC_ALWAYS         4'h0
`define CC_Z              4'h1
`define CC_NZ             4'h2
`define CC_C              4'h3
`define CC_NC             4'h4
`define CC_N              4'h5
`define CC_NN             4'h6
`define CC_V              4'h7

// ****************************************
// lengths, reset values and trap segment
// ****************************************
`define LEN_SHORT         3'h2
`define LEN_LONG          3'h4
`define RST_IP            16'h0000
`define RST_SEG           8'h00
`define RST_WDT_EN        1'b1
`define TRAP_SEG          8'h00

`endif

// [inc/cpu_dec_pkg.sv]
package cpu_dec_pkg;

	typedef enum logic [5:0] {
		OP_ROT_LEFT, OP_ROT_RIGHT, OP_SHR_ARITH,
		OP_MOVE_W_RR, OP_MOVE_W_RI, OP_MOVE_B_RR, OP_MOVE_B_RI,
		OP_EXT_S_RR, OP_EXT_S_RI, OP_EXT_Z_RR, OP_EXT_Z_RI,
		OP_JUMP_ABS, OP_JUMP_IND, OP_JUMP_REL, OP_JUMP_SEG,
		OP_JSET, OP_JSET_CLR, OP_JCLR, OP_JCLR_SET,
		OP_CALL_ABS, OP_CALL_IND, OP_CALL_REL, OP_CALL_SEG, OP_PUSH_CALL,
		OP_CTX_SWITCH, OP_TRAP,
		OP_RET_NEAR, OP_RET_NEAR_POP, OP_RET_FAR, OP_RET_INT,
		OP_POWER_DOWN, OP_WDT_OFF, OP_WDT_ON,
		OP_XSEG_IMM, OP_XSEG_REG, OP_MAC_LOAD, OP_MAC_STORE,
		OP_BAD
	} op_t;

	typedef struct packed {
		logic [15:0] imm;
		logic [3:0]  fld_b;
		logic [3:0]  fld_a;
		logic [7:0]  opcode;
	} instr_t;

	typedef struct packed {
		logic n;
		logic c;
		logic v;
		logic z;
	} flags_t;

	typedef struct packed {
		logic        en;
		logic [3:0]  idx;
		logic [15:0] data;
	} wb_t;

endpackage

// [hw/cpu_instruction_summary_decoder.sv]
`timescale 1ns/10ps
`include "cpu_dec_consts.svh"

//Contract
//- rotates are 2 bytes, rotate register bits
//- arithmetic shift keeps sign, 2 bytes
//- byte-to-word move sign or zero extends
//- word/byte moves in 2 or 4 bytes
//- conditional jumps branch only on condition, 4 bytes
//- segment jump loads segment and target, 4 bytes
//- jump if bit set, clear variant clears
//- jump if bit clear, set variant sets
//- conditional calls push return, 4 bytes
//- segment call pushes segment and offset
//- push-and-call pushes register then calls, segment unchanged
//- context switch pushes, then loads register
//- trap vectors by immediate number, 2 bytes
//- near return 2 bytes, pop variant restores
//- far return restores segment and offset
//- interrupt return restores context, 2 bytes
//- power-down opcode valid, 4 bytes, no effect
//- watchdog off/on instructions, 4 bytes
//- extended segment opens addressing sequence
//- mac load accumulator, store mac register
module cpu_instruction_summary_decoder import cpu_dec_pkg::*; #(
	parameter int SP_W = 4
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// fetch side
	input  wire logic        instr_valid,
	input  wire instr_t      instr,
	input  wire flags_t      flags,
	// decode result
	output logic             done_ff,
	output op_t              op_ff,
	output logic [2:0]       len_ff,
	output logic             bad_ff,
	output logic [15:0]      ip_ff,
	output logic [7:0]       seg_ff,
	output logic             isr_end_ff,
	// write-back
	output wb_t              wb_ff,
	// system state
	output logic             wdt_en_ff,
	output logic [2:0]       ext_left_ff,
	output logic [7:0]       ext_seg_ff,
	output logic             ext_reg_ff,
	output logic [31:0]      acc_ff
);

	// ****************************************
	// functions
	// ****************************************
	function automatic op_t decode_op(input logic [7:0] b);
		unique case (b)
			`OPC_ROT_LEFT:     return OP_ROT_LEFT;
			`OPC_ROT_RIGHT:    return OP_ROT_RIGHT;
			`OPC_SHR_ARITH:    return OP_SHR_ARITH;
			`OPC_MOVE_W_RR:    return OP_MOVE_W_RR;
			`OPC_MOVE_W_RI:    return OP_MOVE_W_RI;
			`OPC_MOVE_B_RR:    return OP_MOVE_B_RR;
			`OPC_MOVE_B_RI:    return OP_MOVE_B_RI;
			`OPC_EXT_S_RR:     return OP_EXT_S_RR;
			`OPC_EXT_S_RI:     return OP_EXT_S_RI;
			`OPC_EXT_Z_RR:     return OP_EXT_Z_RR;
			`OPC_EXT_Z_RI:     return OP_EXT_Z_RI;
			`OPC_JUMP_ABS:     return OP_JUMP_ABS;
			`OPC_JUMP_IND:     return OP_JUMP_IND;
			`OPC_JUMP_REL:     return OP_JUMP_REL;
			`OPC_JUMP_SEG:     return OP_JUMP_SEG;
			`OPC_JSET:         return OP_JSET;
			`OPC_JSET_CLR:     return OP_JSET_CLR;
			`OPC_JCLR:         return OP_JCLR;
			`OPC_JCLR_SET:     return OP_JCLR_SET;
			`OPC_CALL_ABS:     return OP_CALL_ABS;
			`OPC_CALL_IND:     return OP_CALL_IND;
			`OPC_CALL_REL:     return OP_CALL_REL;
			`OPC_CALL_SEG:     return OP_CALL_SEG;
			`OPC_PUSH_CALL:    return OP_PUSH_CALL;
			`OPC_CTX_SWITCH:   return OP_CTX_SWITCH;
			`OPC_TRAP:         return OP_TRAP;
			`OPC_RET_NEAR:     return OP_RET_NEAR;
			`OPC_RET_NEAR_POP: return OP_RET_NEAR_POP;
			`OPC_RET_FAR:      return OP_RET_FAR;
			`OPC_RET_INT:      return OP_RET_INT;
			`OPC_POWER_DOWN:   return OP_POWER_DOWN;
			`OPC_WDT_OFF:      return OP_WDT_OFF;
			`OPC_WDT_ON:       return OP_WDT_ON;
			`OPC_XSEG_IMM:     return OP_XSEG_IMM;
			`OPC_XSEG_REG:     return OP_XSEG_REG;
			`OPC_MAC_LOAD:     return OP_MAC_LOAD;
			`OPC_MAC_STORE:    return OP_MAC_STORE;
			default:           return OP_BAD;
		endcase
	endfunction

	function automatic logic [2:0] op_len(input op_t o);
		if (o inside {OP_ROT_LEFT, OP_ROT_RIGHT, OP_SHR_ARITH, OP_MOVE_W_RR,
			OP_MOVE_B_RR, OP_EXT_S_RR, OP_EXT_Z_RR, OP_TRAP, OP_RET_NEAR,
			OP_RET_NEAR_POP, OP_RET_FAR, OP_RET_INT, OP_XSEG_REG, OP_BAD})
			return `LEN_SHORT;
		return `LEN_LONG;
	endfunction

	function automatic logic cond_met(input logic [3:0] cc, input flags_t f);
		case (cc)
			`CC_ALWAYS: return 1'b1;
			`CC_Z:      return f.z;
			`CC_NZ:     return !f.z;
			`CC_C:      return f.c;
			`CC_NC:     return !f.c;
			`CC_N:      return f.n;
			`CC_NN:     return !f.n;
			`CC_V:      return f.v;
			default:    return 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] sext8(input logic [7:0] b);
		return {{8{b[7]}}, b};
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [15:0]     regs_ff [16];
	logic [15:0]     stk_ff  [2**SP_W];
	logic [SP_W-1:0] sp_ff;

	op_t             opc;
	logic [2:0]      len;
	logic [15:0]     ra;
	logic [15:0]     rb;
	logic            cnd;
	logic            bit_v;
	logic [15:0]     seq_ip;
	logic [15:0]     rel_ip;
	logic [15:0]     top;
	logic [15:0]     below;
	logic [15:0]     nxt_ip;
	logic [7:0]      nxt_seg;
	wb_t             nxt_wb;
	logic [1:0]      push_n;
	logic [15:0]     push_top;
	logic [15:0]     push_deep;
	logic [1:0]      pop_n;

	// ****************************************
	// execute
	// ****************************************
	always_comb begin
		opc       = decode_op(instr.opcode);
		len       = op_len(opc);
		ra        = regs_ff[instr.fld_a];
		rb        = regs_ff[instr.fld_b];
		cnd       = cond_met(instr.fld_b, flags);
		bit_v     = ra[instr.fld_b];
		seq_ip    = ip_ff + 16'(len);
		rel_ip    = seq_ip + {instr.imm[14:0], 1'b0};
		top       = stk_ff[sp_ff];
		below     = stk_ff[sp_ff + SP_W'(1)];
		nxt_ip    = seq_ip;
		nxt_seg   = seg_ff;
		nxt_wb    = '{en: 1'b0, idx: instr.fld_a, data: ra};
		push_n    = 2'h0;
		push_top  = seq_ip;
		push_deep = {8'h00, seg_ff};
		pop_n     = 2'h0;
		unique case (opc)
			OP_ROT_LEFT:  begin nxt_wb.en = 1'b1; nxt_wb.data = {ra[14:0], ra[15]}; end
			OP_ROT_RIGHT: begin nxt_wb.en = 1'b1; nxt_wb.data = {ra[0], ra[15:1]}; end
			OP_SHR_ARITH: begin nxt_wb.en = 1'b1; nxt_wb.data = {ra[15], ra[15:1]}; end
			OP_MOVE_W_RR: begin nxt_wb.en = 1'b1; nxt_wb.data = rb; end
			OP_MOVE_W_RI: begin nxt_wb.en = 1'b1; nxt_wb.data = instr.imm; end
			OP_MOVE_B_RR: begin nxt_wb.en = 1'b1; nxt_wb.data = {ra[15:8], rb[7:0]}; end
			OP_MOVE_B_RI: begin nxt_wb.en = 1'b1; nxt_wb.data = {ra[15:8], instr.imm[7:0]}; end
			OP_EXT_S_RR:  begin nxt_wb.en = 1'b1; nxt_wb.data = sext8(rb[7:0]); end
			OP_EXT_S_RI:  begin nxt_wb.en = 1'b1; nxt_wb.data = sext8(instr.imm[7:0]); end
			OP_EXT_Z_RR:  begin nxt_wb.en = 1'b1; nxt_wb.data = {8'h00, rb[7:0]}; end
			OP_EXT_Z_RI:  begin nxt_wb.en = 1'b1; nxt_wb.data = {8'h00, instr.imm[7:0]}; end
			OP_JUMP_ABS:  if (cnd) nxt_ip = instr.imm;
			OP_JUMP_IND:  if (cnd) nxt_ip = ra;
			OP_JUMP_REL:  if (cnd) nxt_ip = rel_ip;
			OP_JUMP_SEG: begin
				nxt_ip  = instr.imm;
				nxt_seg = {instr.fld_b, instr.fld_a};
			end
			OP_JSET, OP_JSET_CLR: if (bit_v) begin
				nxt_ip = rel_ip;
				nxt_wb.en   = (opc == OP_JSET_CLR);
				nxt_wb.data = ra & ~(16'h0001 << instr.fld_b);
			end
			OP_JCLR, OP_JCLR_SET: if (!bit_v) begin
				nxt_ip = rel_ip;
				nxt_wb.en   = (opc == OP_JCLR_SET);
				nxt_wb.data = ra | (16'h0001 << instr.fld_b);
			end
			OP_CALL_ABS: if (cnd) begin push_n = 2'h1; nxt_ip = instr.imm; end
			OP_CALL_IND: if (cnd) begin push_n = 2'h1; nxt_ip = ra; end
			OP_CALL_REL: if (cnd) begin push_n = 2'h1; nxt_ip = rel_ip; end
			OP_CALL_SEG: begin
				push_n  = 2'h2;
				nxt_ip  = instr.imm;
				nxt_seg = {instr.fld_b, instr.fld_a};
			end
			OP_PUSH_CALL: begin
				push_n    = 2'h2;
				push_deep = ra;
				nxt_ip    = instr.imm;
			end
			OP_CTX_SWITCH: begin
				push_n      = 2'h1;
				push_top    = ra;
				nxt_wb.en   = 1'b1;
				nxt_wb.data = instr.imm;
			end
			OP_TRAP: begin
				push_n  = 2'h2;
				nxt_ip  = {7'h00, instr.fld_b[2:0], instr.fld_a, 2'b00};
				nxt_seg = `TRAP_SEG;
			end
			OP_RET_NEAR: begin pop_n = 2'h1; nxt_ip = top; end
			OP_RET_NEAR_POP: begin
				pop_n       = 2'h2;
				nxt_ip      = top;
				nxt_wb.en   = 1'b1;
				nxt_wb.data = below;
			end
			OP_RET_FAR, OP_RET_INT: begin
				pop_n   = 2'h2;
				nxt_ip  = top;
				nxt_seg = below[7:0];
			end
			OP_MAC_STORE: begin
				nxt_wb.en   = 1'b1;
				nxt_wb.data = instr.fld_b[0] ? acc_ff[31:16] : acc_ff[15:0];
			end
			OP_POWER_DOWN, OP_WDT_OFF, OP_WDT_ON, OP_XSEG_IMM, OP_XSEG_REG,
			OP_MAC_LOAD, OP_BAD: ;
		endcase
	end

	// ****************************************
	// sequencing and result
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ip_ff      <= `RST_IP;
			seg_ff     <= `RST_SEG;
			done_ff    <= 1'b0;
			op_ff      <= OP_BAD;
			len_ff     <= `LEN_SHORT;
			bad_ff     <= 1'b0;
			isr_end_ff <= 1'b0;
			wb_ff      <= '0;
		end else begin
			done_ff    <= instr_valid;
			isr_end_ff <= instr_valid && (opc == OP_RET_INT);
			wb_ff.en   <= instr_valid && nxt_wb.en;
			if (instr_valid) begin
				ip_ff       <= nxt_ip;
				seg_ff      <= nxt_seg;
				op_ff       <= opc;
				len_ff      <= len;
				bad_ff      <= (opc == OP_BAD);
				wb_ff.idx   <= nxt_wb.idx;
				wb_ff.data  <= nxt_wb.data;
			end
		end
	end

	// ****************************************
	// register file
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) regs_ff[i] <= 16'h0000;
		end else if (instr_valid && nxt_wb.en) begin
			regs_ff[nxt_wb.idx] <= nxt_wb.data;
		end
	end

	// ****************************************
	// system stack
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sp_ff <= '0;
			for (int i = 0; i < 2**SP_W; i++) stk_ff[i] <= 16'h0000;
		end else if (instr_valid) begin
			if (push_n == 2'h1) begin
				stk_ff[sp_ff - SP_W'(1)] <= push_top;
				sp_ff <= sp_ff - SP_W'(1);
			end else if (push_n == 2'h2) begin
				stk_ff[sp_ff - SP_W'(1)] <= push_deep;
				stk_ff[sp_ff - SP_W'(2)] <= push_top;
				sp_ff <= sp_ff - SP_W'(2);
			end else begin
				sp_ff <= sp_ff + SP_W'(pop_n);
			end
		end
	end

	// ****************************************
	// watchdog, extension, mac
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			wdt_en_ff <= `RST_WDT_EN;
		else if (instr_valid && opc == OP_WDT_OFF)
			wdt_en_ff <= 1'b0;
		else if (instr_valid && opc == OP_WDT_ON)
			wdt_en_ff <= 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ext_left_ff <= 3'h0;
			ext_seg_ff  <= 8'h00;
			ext_reg_ff  <= 1'b0;
		end else if (instr_valid && opc inside {OP_XSEG_IMM, OP_XSEG_REG}) begin
			ext_left_ff <= {1'b0, instr.fld_b[1:0]} + 3'h1;
			ext_seg_ff  <= (opc == OP_XSEG_IMM) ? instr.imm[7:0] : ra[7:0];
			ext_reg_ff  <= instr.fld_b[2];
		end else if (instr_valid && ext_left_ff != 3'h0) begin
			ext_left_ff <= ext_left_ff - 3'h1;
			if (ext_left_ff == 3'h1) ext_reg_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			acc_ff <= 32'h0000_0000;
		else if (instr_valid && opc == OP_MAC_LOAD)
			acc_ff <= {rb, ra};
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_rot_left_data: assert property (
		instr_valid && opc == OP_ROT_LEFT |=> len_ff == `LEN_SHORT && wb_ff.en
			&& wb_ff.data == {$past(ra[14:0]), $past(ra[15])})
		else $error("rotate left result wrong");
	chk_shr_sign_kept: assert property (
		instr_valid && opc == OP_SHR_ARITH |=> wb_ff.data[15:14] == {2{$past(ra[15])}}
			&& len_ff == `LEN_SHORT)
		else $error("arithmetic shift lost sign");
	chk_ext_sign_fill: assert property (
		instr_valid && opc == OP_EXT_S_RR |=> wb_ff.data[15:8] == {8{$past(rb[7])}})
		else $error("sign extension wrong");
	chk_jump_not_taken: assert property (
		instr_valid && opc == OP_JUMP_ABS && !cnd |=> ip_ff == $past(ip_ff) + 16'h0004)
		else $error("jump taken without condition");
	chk_jset_clear_bit: assert property (
		instr_valid && opc == OP_JSET_CLR && bit_v
			|=> wb_ff.en && !wb_ff.data[$past(instr.fld_b)] && ip_ff == $past(rel_ip))
		else $error("bit not cleared on taken branch");
	chk_seg_call_push: assert property (
		instr_valid && opc == OP_CALL_SEG |=> sp_ff == $past(sp_ff) - SP_W'(2)
			&& stk_ff[sp_ff] == $past(seq_ip) && seg_ff == $past(instr[15:8]))
		else $error("segment call stack wrong");
	chk_trap_vector: assert property (
		instr_valid && opc == OP_TRAP |=> ip_ff[1:0] == 2'b00 && len_ff == `LEN_SHORT
			&& ip_ff[9:2] == {1'b0, $past(instr.fld_b[2:0]), $past(instr.fld_a)})
		else $error("trap vector wrong");
	chk_power_down_none: assert property (
		instr_valid && opc == OP_POWER_DOWN |=> !wb_ff.en && !bad_ff
			&& $stable(sp_ff) && $stable(wdt_en_ff) && len_ff == `LEN_LONG)
		else $error("power-down opcode had effect");
	chk_wdt_off: assert property (
		instr_valid && opc == OP_WDT_OFF |=> !wdt_en_ff && len_ff == `LEN_LONG)
		else $error("watchdog not switched off");
	chk_ext_count: assert property (
		instr_valid && opc == OP_XSEG_IMM |=> ext_left_ff != 3'h0
			&& ext_seg_ff == $past(instr.imm[7:0]))
		else $error("extended sequence not opened");
	chk_len_legal: assert property (
		done_ff |-> len_ff == `LEN_SHORT || len_ff == `LEN_LONG)
		else $error("illegal instruction length");

	cov_call_then_ret: cover property (
		instr_valid && opc == OP_CALL_ABS && cnd ##[1:8] instr_valid && opc == OP_RET_NEAR);
	cov_jset_taken: cover property (instr_valid && opc == OP_JSET_CLR && bit_v);
	cov_ext_sequence: cover property (ext_left_ff == 3'h2 ##[1:8] ext_left_ff == 3'h0);

endmodule // cpu_instruction_summary_decoder

// [verification/cpu_instruction_summary_decoder_bench.sv]
`timescale 1ns/10ps
`include "cpu_dec_consts.svh"
module cpu_instruction_summary_decoder_bench import cpu_dec_pkg::*; ;
	// ****************************************
	// notes and signals
	// ****************************************
	typedef struct packed {
		op_t         op;
		logic [2:0]  len;
		logic        bad;
		logic        isr;
		logic [15:0] ip;
		logic [7:0]  seg;
		wb_t         wb;
		logic [15:0] msk;
		logic        wdt;
		logic [31:0] acc;
		logic        xchk;
		logic [11:0] xst;
	} note_t;
	logic        core_clk;
	logic        rst_n;
	logic        instr_valid;
	instr_t      instr;
	flags_t      flags;
	flags_t      fl;
	logic        done_ff;
	op_t         op_ff;
	logic [2:0]  len_ff;
	logic        bad_ff;
	logic [15:0] ip_ff;
	logic [7:0]  seg_ff;
	logic        isr_end_ff;
	wb_t         wb_ff;
	logic        wdt_en_ff;
	logic [2:0]  ext_left_ff;
	logic [7:0]  ext_seg_ff;
	logic        ext_reg_ff;
	logic [31:0] acc_ff;
	logic [15:0] rf [16];
	logic [15:0] stk [$];
	logic [15:0] m_ip;
	logic [7:0]  m_seg;
	logic        m_wdt;
	logic [31:0] m_acc;
	note_t       q [$];
	int          errors;
	int          cmp_count;
	logic [7:0]  opc_tab [37] = '{`OPC_ROT_LEFT, `OPC_ROT_RIGHT, `OPC_SHR_ARITH,
		`OPC_MOVE_W_RR, `OPC_MOVE_W_RI, `OPC_MOVE_B_RR, `OPC_MOVE_B_RI, `OPC_EXT_S_RR,
		`OPC_EXT_S_RI, `OPC_EXT_Z_RR, `OPC_EXT_Z_RI, `OPC_JUMP_ABS, `OPC_JUMP_IND,
		`OPC_JUMP_REL, `OPC_JUMP_SEG, `OPC_JSET, `OPC_JSET_CLR, `OPC_JCLR, `OPC_JCLR_SET,
		`OPC_CALL_ABS, `OPC_CALL_IND, `OPC_CALL_REL, `OPC_CALL_SEG, `OPC_PUSH_CALL,
		`OPC_CTX_SWITCH, `OPC_TRAP, `OPC_RET_NEAR, `OPC_RET_NEAR_POP, `OPC_RET_FAR,
		`OPC_RET_INT, `OPC_POWER_DOWN, `OPC_WDT_OFF, `OPC_WDT_ON, `OPC_XSEG_IMM,
		`OPC_XSEG_REG, `OPC_MAC_LOAD, `OPC_MAC_STORE};
	logic [7:0]  ext_ops [4] = '{`OPC_EXT_S_RR, `OPC_EXT_S_RI, `OPC_EXT_Z_RR, `OPC_EXT_Z_RI};

	cpu_instruction_summary_decoder #(.SP_W(4)) u_dut (
		.core_clk    (core_clk),
		.rst_n       (rst_n),
		.instr_valid (instr_valid),
		.instr       (instr),
		.flags       (flags),
		.done_ff     (done_ff),
		.op_ff       (op_ff),
		.len_ff      (len_ff),
		.bad_ff      (bad_ff),
		.ip_ff       (ip_ff),
		.seg_ff      (seg_ff),
		.isr_end_ff  (isr_end_ff),
		.wb_ff       (wb_ff),
		.wdt_en_ff   (wdt_en_ff),
		.ext_left_ff (ext_left_ff),
		.ext_seg_ff  (ext_seg_ff),
		.ext_reg_ff  (ext_reg_ff),
		.acc_ff      (acc_ff)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ****************************************
	// compare and model
	// ****************************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic cond(input logic [3:0] c, input flags_t f);
		case (c)
			4'h0: return 1'b1;
			4'h1: return f.z;
			4'h2: return !f.z;
			4'h3: return f.c;
			4'h4: return !f.c;
			4'h5: return f.n;
			4'h6: return !f.n;
			4'h7: return f.v;
			default: return 1'b0;
		endcase
	endfunction

	task automatic put(inout note_t n, input logic [3:0] i, input logic [15:0] d,
		input logic [15:0] m);
		n.wb = '{1'b1, i, d};
		n.msk = m;
		// partial or unknown results leave the model register unknown
		rf[i] = (m == 16'hffff) ? d : 16'hxxxx;
	endtask

	task automatic call(inout logic [15:0] nip, input logic [15:0] tgt);
		stk.push_back(nip);
		nip = tgt;
	endtask

	task automatic issue(input logic [7:0] opc, input logic [3:0] a, input logic [3:0] b,
		input logic [15:0] imm);
		note_t       n;
		logic [15:0] nip, ra, rb, rel;
		logic        t;
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr <= {imm, b, a, opc};
		flags <= fl;
		n = '0;
		n.op = OP_BAD;
		foreach (opc_tab[k])
			if (opc_tab[k] == opc) n.op = op_t'(k);
		n.len = (n.op inside {[OP_ROT_LEFT:OP_SHR_ARITH], OP_MOVE_W_RR, OP_MOVE_B_RR,
			OP_EXT_S_RR, OP_EXT_Z_RR, [OP_TRAP:OP_RET_INT], OP_XSEG_REG, OP_BAD}) ? 3'h2 : 3'h4;
		ra = rf[a];
		rb = rf[b];
		t = cond(b, fl);
		nip = m_ip + 16'(n.len);
		rel = nip + {imm[14:0], 1'b0};
		case (n.op)
			OP_ROT_LEFT: put(n, a, {ra[14:0], ra[15]}, 16'hffff);
			OP_ROT_RIGHT: put(n, a, {ra[0], ra[15:1]}, 16'hffff);
			OP_SHR_ARITH: put(n, a, {ra[15], ra[15:1]}, 16'hffff);
			OP_MOVE_W_RR: put(n, a, rb, 16'hffff);
			OP_MOVE_W_RI: put(n, a, imm, 16'hffff);
			OP_MOVE_B_RR: put(n, a, rb, 16'h00ff);
			OP_MOVE_B_RI: put(n, a, imm, 16'h00ff);
			OP_EXT_S_RR: put(n, a, {{8{rb[7]}}, rb[7:0]}, 16'hffff);
			OP_EXT_S_RI: put(n, a, {{8{imm[7]}}, imm[7:0]}, 16'hffff);
			OP_EXT_Z_RR: put(n, a, {8'h00, rb[7:0]}, 16'hffff);
			OP_EXT_Z_RI: put(n, a, {8'h00, imm[7:0]}, 16'hffff);
			OP_JUMP_ABS: if (t) nip = imm;
			OP_JUMP_IND: if (t) nip = ra;
			OP_JUMP_REL: if (t) nip = rel;
			OP_JUMP_SEG: begin
				nip = imm;
				m_seg = {b, a};
			end
			OP_JSET, OP_JSET_CLR: if (ra[b]) begin
				nip = rel;
				if (n.op == OP_JSET_CLR) put(n, a, ra & ~(16'h0001 << b), 16'hffff);
			end
			OP_JCLR, OP_JCLR_SET: if (!ra[b]) begin
				nip = rel;
				if (n.op == OP_JCLR_SET) put(n, a, ra | (16'h0001 << b), 16'hffff);
			end
			OP_CALL_ABS: if (t) call(nip, imm);
			OP_CALL_IND: if (t) call(nip, ra);
			OP_CALL_REL: if (t) call(nip, rel);
			OP_CALL_SEG: begin
				stk.push_back({8'h00, m_seg});
				call(nip, imm);
				m_seg = {b, a};
			end
			OP_PUSH_CALL: begin
				stk.push_back(ra);
				call(nip, imm);
			end
			OP_CTX_SWITCH: begin
				stk.push_back(ra);
				put(n, a, imm, 16'hffff);
			end
			OP_TRAP: begin
				stk.push_back({8'h00, m_seg});
				call(nip, {7'h00, b[2:0], a, 2'h0});
				m_seg = 8'h00;
			end
			OP_RET_NEAR: nip = stk.pop_back();
			OP_RET_NEAR_POP: begin
				nip = stk.pop_back();
				put(n, a, stk.pop_back(), 16'hffff);
			end
			OP_RET_FAR, OP_RET_INT: begin
				nip = stk.pop_back();
				m_seg = 8'(stk.pop_back());
				n.isr = (n.op == OP_RET_INT);
			end
			OP_WDT_OFF: m_wdt = 1'b0;
			OP_WDT_ON: m_wdt = 1'b1;
			OP_XSEG_IMM: begin
				n.xchk = 1'b1;
				n.xst = {{1'b0, b[1:0]} + 3'h1, imm[7:0], b[2]};
			end
			OP_XSEG_REG: begin
				n.xchk = 1'b1;
				n.xst = {{1'b0, b[1:0]} + 3'h1, ra[7:0], b[2]};
			end
			OP_MAC_LOAD: m_acc = {rb, ra};
			OP_MAC_STORE: put(n, a, b[0] ? m_acc[31:16] : m_acc[15:0], 16'hffff);
			OP_BAD: n.bad = 1'b1;
			default: ;
		endcase
		m_ip = nip;
		n.ip = nip;
		n.seg = m_seg;
		n.wdt = m_wdt;
		n.acc = m_acc;
		q.push_back(n);
	endtask

	task automatic chk(input note_t n);
		cmp(32'(op_ff), 32'(n.op));
		cmp(32'({len_ff, bad_ff, isr_end_ff}), 32'({n.len, n.bad, n.isr}));
		cmp(32'({ip_ff, seg_ff}), 32'({n.ip, n.seg}));
		cmp(32'({wb_ff.en, n.wb.en ? wb_ff.idx : 4'h0}), 32'({n.wb.en, n.wb.idx}));
		cmp(32'(wb_ff.data & n.msk), 32'(n.wb.data & n.msk));
		cmp(acc_ff, n.acc);
		cmp(32'(wdt_en_ff), 32'(n.wdt));
		if (n.xchk) cmp(32'({ext_left_ff, ext_seg_ff, ext_reg_ff}), 32'(n.xst));
	endtask

	always @(negedge core_clk) begin
		if (rst_n === 1'b1 && done_ff !== 1'b0) begin
			if (q.size() == 0) cmp(32'(done_ff), 32'h0);
			else chk(q.pop_front());
		end else if (rst_n === 1'b1) begin
			cmp(32'({wb_ff.en, isr_end_ff}), 32'h0);
		end
	end

	// ****************************************
	// sequencing
	// ****************************************
	task automatic idle(input int n, input string s);
		repeat (n) begin
			@(posedge core_clk);
			instr_valid <= 1'b0;
			instr <= instr_t'($urandom());
		end
		$display("test done: %s", s);
	endtask

	task automatic do_reset();
		@(posedge core_clk);
		rst_n <= 1'b0;
		instr_valid <= 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (rf[i]) rf[i] = 16'h0000;
		stk.delete();
		q.delete();
		m_ip = 16'h0000;
		m_seg = 8'h00;
		m_wdt = 1'b1;
		m_acc = 32'h0;
		@(negedge core_clk);
		cmp({ip_ff, seg_ff, len_ff, bad_ff, wdt_en_ff, ext_left_ff}, 32'h0000_0048);
		cmp(32'({op_ff, ext_seg_ff, ext_reg_ff, done_ff}), 32'({OP_BAD, 10'h0}));
		cmp(acc_ff | 32'(wb_ff), 32'h0);
	endtask

	task automatic results();
		$display("counts: %0d compares, %0d errors", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		results();
	end

	initial begin
		rst_n = 1'b0;
		instr_valid = 1'b0;
		instr = '0;
		flags = '0;
		fl = '0;
		errors = 0;
		cmp_count = 0;
		void'($urandom(12));
		do_reset();
		for (int i = 0; i < 8; i++)
			issue(`OPC_MOVE_W_RI, 4'(i), 4'h0, 16'($urandom()));
		issue(`OPC_MOVE_W_RR, 4'h8, 4'h1, 16'h0000);
		foreach (ext_ops[k])
			for (int s = 0; s < 2; s++)
				issue(ext_ops[k], 4'h9, 4'(2 + s), s ? 16'hff80 : 16'h017f);
		issue(`OPC_MOVE_B_RR, 4'hb, 4'h2, 16'h0000);
		issue(`OPC_MOVE_B_RI, 4'hb, 4'h0, 16'h12a5);
		issue(`OPC_MOVE_W_RI, 4'he, 4'h0, 16'h8001);
		issue(`OPC_SHR_ARITH, 4'he, 4'h1, 16'h0000);
		issue(`OPC_MOVE_W_RI, 4'he, 4'h0, 16'h4000);
		issue(`OPC_SHR_ARITH, 4'he, 4'h1, 16'h0000);
		issue(`OPC_ROT_LEFT, 4'h0, 4'h1, 16'h0000);
		issue(`OPC_ROT_RIGHT, 4'h0, 4'h1, 16'h0000);
		idle(3, "moves and shifts");
		for (int c = 0; c < 16; c++) begin
			fl = flags_t'(4'($urandom()));
			issue(opc_tab[11 + c % 3], 4'(c % 8), 4'(c), 16'($urandom()));
		end
		issue(`OPC_JUMP_SEG, 4'h4, 4'h3, 16'h0100);
		issue(`OPC_MOVE_W_RI, 4'h4, 4'h0, 16'h00f0);
		issue(`OPC_JSET, 4'h4, 4'h4, 16'h0010);
		issue(`OPC_JSET, 4'h4, 4'h0, 16'h0010);
		issue(`OPC_JSET_CLR, 4'h4, 4'h5, 16'h8003);
		issue(`OPC_JCLR, 4'h4, 4'h7, 16'h0020);
		issue(`OPC_JCLR_SET, 4'h4, 4'h1, 16'h0006);
		issue(`OPC_JCLR_SET, 4'h4, 4'h1, 16'h0006);
		idle(3, "jumps");
		fl = flags_t'(4'h1);
		issue(`OPC_MOVE_W_RI, 4'h5, 4'h0, 16'h1234);
		issue(`OPC_CALL_ABS, 4'h0, 4'h0, 16'h0200);
		issue(`OPC_CALL_REL, 4'h0, 4'h1, 16'h0040);
		issue(`OPC_CALL_IND, 4'h5, 4'h2, 16'h0000);
		issue(`OPC_CALL_IND, 4'h5, 4'hf, 16'h0000);
		issue(`OPC_RET_NEAR, 4'h0, 4'h0, 16'h0000);
		issue(`OPC_RET_NEAR, 4'h0, 4'h0, 16'h0000);
		issue(`OPC_PUSH_CALL, 4'h5, 4'h0, 16'h0300);
		issue(`OPC_RET_NEAR_POP, 4'h6, 4'h0, 16'h0000);
		issue(`OPC_CALL_ABS, 4'h0, 4'h0, 16'h0500);
		issue(`OPC_CTX_SWITCH, 4'h5, 4'h0, 16'hbeef);
		issue(`OPC_RET_NEAR_POP, 4'h5, 4'h0, 16'h0000);
		issue(`OPC_CALL_SEG, 4'h3, 4'h2, 16'h0400);
		issue(`OPC_TRAP, 4'h5, 4'h3, 16'h0000);
		issue(`OPC_RET_INT, 4'h0, 4'h0, 16'h0000);
		issue(`OPC_RET_FAR, 4'h0, 4'h0, 16'h0000);
		idle(3, "segment_call, trap and returns");
		issue(`OPC_WDT_OFF, 4'h0, 4'h0, 16'h0000);
		issue(`OPC_POWER_DOWN, 4'h0, 4'h0, 16'h0000);
		issue(`OPC_WDT_ON, 4'h0, 4'h0, 16'h0000);
		issue(`OPC_MAC_LOAD, 4'h0, 4'h1, 16'h0000);
		issue(`OPC_MAC_STORE, 4'hc, 4'h0, 16'h0000);
		issue(`OPC_MAC_STORE, 4'hd, 4'h1, 16'h0000);
		issue(`OPC_XSEG_IMM, 4'h0, 4'h7, 16'h00a5);
		issue(`OPC_XSEG_REG, 4'h5, 4'h0, 16'h0000);
		issue(8'hff, 4'h0, 4'h0, 16'($urandom()));
		issue(8'h00, 4'h0, 4'h0, 16'h0000);
		issue(`OPC_WDT_OFF, 4'h0, 4'h0, 16'h0000);
		idle(3, "system and bad opcodes");
		do_reset();
		idle(1, "reset in mid-run");
		cmp(32'(q.size()), 32'h0);
		results();
	end
endmodule // cpu_instruction_summary_decoder_bench
